// >>> design/kms_pkg.sv
// Shared constants and types of the switch security supervisor
package kms_pkg;

	// Number of host computers sharing the peripherals
	localparam int HOST_COUNT = 4;
	// Width of the selected-host index
	localparam int SEL_WIDTH  = 2;

	// Width of the shared cycle counter
	localparam int CNT_WIDTH = 10;
	// Cycles spent purging interface buffers (start-up and switch)
	localparam logic [CNT_WIDTH-1:0] PURGE_LAST   = 10'h00F;
	// Cycles allowed for one self-test step before it counts as failed
	localparam logic [CNT_WIDTH-1:0] TEST_TIMEOUT = 10'h3E7;

	// Self-test steps, run in this order
	localparam logic [1:0] TEST_INTEGRITY = 2'h0;
	localparam logic [1:0] TEST_ISOLATION = 2'h1;
	localparam logic [1:0] TEST_SELECTION = 2'h2;
	localparam logic [1:0] TEST_TAMPER    = 2'h3;
	localparam logic [1:0] TEST_LAST_IDX  = TEST_TAMPER;

	// Values after reset
	localparam logic [SEL_WIDTH-1:0] SEL_RESET = 2'h0;

	// Supervisor states
	typedef enum logic [2:0] {
		ST_INIT_PURGE,
		ST_SELFTEST,
		ST_NORMAL,
		ST_SWITCH_PURGE,
		ST_CONFIG,
		ST_FAILED,
		ST_TAMPERED
	} kms_state_t;

endpackage : kms_pkg

// >>> design/kms_sync.sv
// Two-flop synchroniser for a bank of asynchronous pin inputs
`timescale 1ns/1ps
module kms_sync #(
	parameter int W = 8
) (
	input  wire logic         clk, // System clock
	input  wire logic         rst, // Asynchronous reset, active high
	input  wire logic [W-1:0] d,   // Raw pin levels
	output logic      [W-1:0] q    // Synchronised levels
);

	logic [W-1:0] stage1_r;

	// First stage feeds only the second stage, never any logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_r <= '0;
			q        <= '0;
		end else begin
			stage1_r <= d;
			q        <= stage1_r;
		end
	end

endmodule : kms_sync

// >>> design/kms_supervisor.sv
// Security supervisor: purge, self-test, tamper lockout and indication
//
// What this block does
// (RULE1) Switching host purges previous host's buffer
// (RULE2) Start-up purges all interface buffers first
// (RULE3) Enclosure tamper detected and recorded unambiguously
// (RULE4) Tamper state stays visible for later inspection
// (RULE5) Opening or battery damage disables device permanently
// (RULE6) After tamper, all routing off forever
// (RULE7) Self-test or anti-tamper failure disables routing
// (RULE8) Tests: integrity, isolation, selection, anti-tamper
// (RULE9) Self-test at power-up and reset button
// (RULE10) Self-test failure lights the failure lamp
// (RULE11) Selected host always shown on lamps
// (RULE12) Admin functions need authenticated key first
// (RULE13) Routing only in normal, untampered, unfailed operation
// (RULE14) Failure held to reset; tamper never cleared
`timescale 1ns/1ps
module kms_supervisor #(
	parameter int NUM_HOSTS = kms_pkg::HOST_COUNT,
	parameter int SEL_W     = kms_pkg::SEL_WIDTH
) (
	input  wire logic                 clk,           // System clock, 25 MHz
	input  wire logic                 rst,           // Asynchronous reset, active high
	input  wire logic [NUM_HOSTS-1:0] selBtn,        // Host select buttons, pin
	input  wire logic                 resetBtn,      // Front reset button, pin
	input  wire logic                 enclosureOpen, // Enclosure switch open, pin
	input  wire logic                 batteryFault,  // Anti-tamper battery damaged, pin
	input  wire logic                 tamperStored,  // Battery-backed tamper record, pin
	input  wire logic                 adminReq,      // Administrator access request, pin
	input  wire logic                 adminKey,      // Assigned admin key present, pin
	input  wire logic                 testDone,      // Self-test step finished
	input  wire logic                 testPass,      // Self-test step result
	output logic                      routeEn,       // Peripheral routing allowed
	output logic      [NUM_HOSTS-1:0] routeSel,      // One-hot routed host
	output logic      [NUM_HOSTS-1:0] bufClear,      // Per-host buffer purge
	output logic      [NUM_HOSTS-1:0] selLed,        // Selected-host lamps
	output logic                      failLed,       // Self-test failure lamp
	output logic                      tamperLed,     // Tamper indication lamp
	output logic                      tamperStore,   // Write tamper to backed store
	output logic                      testStart,     // Start one self-test step
	output logic      [1:0]           testIdx,       // Self-test step in progress
	output logic                      adminGrant,    // Admin functions open
	output logic                      adminDenied    // Admin request refused
);

	localparam int SW = NUM_HOSTS + 6;

	kms_pkg::kms_state_t state_r, state_nxt;
	logic [kms_pkg::CNT_WIDTH-1:0] cnt_r, cnt_nxt;
	logic [SEL_W-1:0]     selIdx_r, selIdx_nxt;
	logic [SEL_W-1:0]     oldIdx_r, oldIdx_nxt;
	logic [1:0]           testIdx_nxt;
	logic                 testWait_r, testWait_nxt;
	logic                 testStart_nxt;
	logic                 denied_nxt;
	logic                 tamper_r;
	logic [SW-1:0]        syncIn;
	logic [SW-1:0]        syncOut;
	logic [NUM_HOSTS-1:0] selS;
	logic [NUM_HOSTS-1:0] selPrev_r;
	logic                 resetPrev_r;
	logic                 adminPrev_r;
	logic [SEL_W-1:0]     btnIdx;
	logic [NUM_HOSTS-1:0] selOh;
	logic [NUM_HOSTS-1:0] clrNxt;

	// All pins cross into the clock domain through two flops
	assign syncIn = {selBtn, resetBtn, enclosureOpen, batteryFault,
		tamperStored, adminReq, adminKey};

	kms_sync #(
		.W (SW)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (syncIn),
		.q   (syncOut)
	);

	// Named views of the synchronised pins
	wire resetS     = syncOut[5];
	wire openS      = syncOut[4];
	wire battS      = syncOut[3];
	wire storedS    = syncOut[2];
	wire adminReqS  = syncOut[1];
	wire adminKeyS  = syncOut[0];
	assign selS     = syncOut[SW-1:6];

	// Edge detection on the synchronised levels
	wire [NUM_HOSTS-1:0] btnRise = selS & ~selPrev_r;
	wire btnAny      = |btnRise;
	wire resetRise   = resetS & ~resetPrev_r;
	wire adminRise   = adminReqS & ~adminPrev_r;

	// Any tamper source, or an earlier record, locks the device
	wire tamperNow   = openS | battS | storedS | tamper_r; // RULE3 RULE5

	// Counter end markers
	wire purgeDone   = (cnt_r == kms_pkg::PURGE_LAST);
	wire testTimeout = (cnt_r == kms_pkg::TEST_TIMEOUT);

	// Lowest pressed button wins when several rise together
	always_comb begin
		btnIdx = '0;
		for (int i = NUM_HOSTS - 1; i >= 0; i--) begin
			if (btnRise[i]) begin
				btnIdx = SEL_W'(i);
			end
		end
	end

	// Supervisor sequencing; tamper outranks everything, then reset button
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r + 10'h001;
		selIdx_nxt    = selIdx_r;
		oldIdx_nxt    = oldIdx_r;
		testIdx_nxt   = testIdx;
		testWait_nxt  = testWait_r;
		testStart_nxt = 1'b0;
		denied_nxt    = 1'b0;
		if (tamperNow) begin
			state_nxt = kms_pkg::ST_TAMPERED; // RULE6
		end else if (resetRise) begin
			state_nxt = kms_pkg::ST_INIT_PURGE; // RULE9 RULE14
			cnt_nxt   = '0;
		end else begin
			case (state_r)
				kms_pkg::ST_INIT_PURGE: begin
					// Every host buffer is wiped before the tests start
					if (purgeDone) begin
						state_nxt    = kms_pkg::ST_SELFTEST; // RULE2
						cnt_nxt      = '0;
						testIdx_nxt  = kms_pkg::TEST_INTEGRITY;
						testWait_nxt = 1'b0;
					end
				end
				kms_pkg::ST_SELFTEST: begin
					if (!testWait_r) begin
						testStart_nxt = 1'b1; // RULE8
						testWait_nxt  = 1'b1;
						cnt_nxt       = '0;
					end else if (testDone) begin
						if (!testPass) begin
							state_nxt = kms_pkg::ST_FAILED; // RULE7
						end else if (testIdx == kms_pkg::TEST_LAST_IDX) begin
							state_nxt = kms_pkg::ST_NORMAL; // RULE9
						end else begin
							testIdx_nxt  = testIdx + 2'h1; // RULE8
							testWait_nxt = 1'b0;
						end
					end else if (testTimeout) begin
						// A silent test engine is treated as a failure
						state_nxt = kms_pkg::ST_FAILED; // RULE7
					end
				end
				kms_pkg::ST_NORMAL: begin
					if (btnAny && (btnIdx != selIdx_r)) begin
						oldIdx_nxt = selIdx_r; // RULE1
						selIdx_nxt = btnIdx;
						state_nxt  = kms_pkg::ST_SWITCH_PURGE;
						cnt_nxt    = '0;
					end else if (adminRise) begin
						if (adminKeyS) begin
							state_nxt = kms_pkg::ST_CONFIG; // RULE12
						end else begin
							denied_nxt = 1'b1; // RULE12
						end
					end
				end
				kms_pkg::ST_SWITCH_PURGE: begin
					if (purgeDone) begin
						state_nxt = kms_pkg::ST_NORMAL;
					end
				end
				kms_pkg::ST_CONFIG: begin
					// Losing the key also closes the session at once
					if (!adminReqS || !adminKeyS) begin
						state_nxt = kms_pkg::ST_NORMAL;
					end
				end
				kms_pkg::ST_FAILED: begin
					state_nxt = kms_pkg::ST_FAILED; // RULE14
				end
				kms_pkg::ST_TAMPERED: begin
					state_nxt = kms_pkg::ST_TAMPERED; // RULE6
				end
				default: begin
					state_nxt = kms_pkg::ST_FAILED;
				end
			endcase
		end
	end

	// Per-host lamp and purge decode from the next state
	genvar h;
	generate
		for (h = 0; h < NUM_HOSTS; h++) begin : g_host
			assign selOh[h]  = (selIdx_nxt == SEL_W'(h)); // RULE11
			assign clrNxt[h] = (state_nxt == kms_pkg::ST_INIT_PURGE) ||
				((state_nxt == kms_pkg::ST_SWITCH_PURGE) && (oldIdx_nxt == SEL_W'(h)));
		end
	endgenerate

	// Routing only in plain normal operation
	wire routeNxt = (state_nxt == kms_pkg::ST_NORMAL); // RULE13

	// State and bookkeeping registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r     <= kms_pkg::ST_INIT_PURGE;
			cnt_r       <= '0;
			selIdx_r    <= kms_pkg::SEL_RESET;
			oldIdx_r    <= kms_pkg::SEL_RESET;
			testWait_r  <= 1'b0;
			selPrev_r   <= '0;
			resetPrev_r <= 1'b0;
			adminPrev_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			selIdx_r    <= selIdx_nxt;
			oldIdx_r    <= oldIdx_nxt;
			testWait_r  <= testWait_nxt;
			selPrev_r   <= selS;
			resetPrev_r <= resetS;
			adminPrev_r <= adminReqS;
		end
	end

	// Tamper record is sticky; only a power-on reset of this flop clears it,
	// and the backed store brings it straight back
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tamper_r    <= 1'b0;
			tamperStore <= 1'b0;
			tamperLed   <= 1'b0;
		end else begin
			tamper_r    <= tamperNow;    // RULE14
			tamperStore <= tamperNow;    // RULE3
			tamperLed   <= tamperNow;    // RULE4
		end
	end

	// Registered outputs, all following the next state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			routeEn     <= 1'b0;
			routeSel    <= '0;
			bufClear    <= '1;
			selLed      <= {{(NUM_HOSTS-1){1'b0}}, 1'b1};
			failLed     <= 1'b0;
			testStart   <= 1'b0;
			testIdx     <= kms_pkg::TEST_INTEGRITY;
			adminGrant  <= 1'b0;
			adminDenied <= 1'b0;
		end else begin
			routeEn     <= routeNxt;                            // RULE13
			routeSel    <= routeNxt ? selOh : '0;               // RULE6
			bufClear    <= clrNxt;                              // RULE1 RULE2
			selLed      <= selOh;                               // RULE11
			failLed     <= (state_nxt == kms_pkg::ST_FAILED);   // RULE10
			testStart   <= testStart_nxt;
			testIdx     <= testIdx_nxt;
			adminGrant  <= (state_nxt == kms_pkg::ST_CONFIG);   // RULE12
			adminDenied <= denied_nxt;
		end
	end

	// Routing exists only while the supervisor sits in normal operation
	route_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE13
		routeEn |-> (state_r == kms_pkg::ST_NORMAL) && !tamper_r && !failLed)
		else $error("routing enabled outside normal operation");

	// A tamper record keeps every path shut
	tamper_lock_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		tamper_r |-> (state_r == kms_pkg::ST_TAMPERED) && !routeEn && (routeSel == '0))
		else $error("routing possible after tamper");

	// Opening the case locks the device on the next edge
	tamper_entry_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		(openS || battS) |=> (state_r == kms_pkg::ST_TAMPERED) && tamperStore && tamperLed)
		else $error("tamper source not acted on");

	// The tamper record never drops once written
	store_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE14
		tamperStore |=> tamperStore)
		else $error("tamper record cleared");

	// Switching purges the old host's buffer with routing off
	switch_purge_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		(state_r == kms_pkg::ST_NORMAL && btnAny && btnIdx != selIdx_r && !tamperNow && !resetRise)
		|=> (!routeEn && bufClear[oldIdx_r] && !bufClear[selIdx_r]) [*8])
		else $error("old host buffer not purged on switch");

	// Start-up wipes every buffer before any test runs
	startup_purge_a: assert property (@(posedge clk) disable iff (rst) // RULE2
		(state_r == kms_pkg::ST_INIT_PURGE) |-> (&bufClear) && !routeEn && !testStart)
		else $error("start-up purge incomplete");

	// A failing step ends in the failed state with the lamp lit
	test_fail_a: assert property (@(posedge clk) disable iff (rst) // RULE7
		(state_r == kms_pkg::ST_SELFTEST && testWait_r && testDone && !testPass
			&& !tamperNow && !resetRise)
		|=> (state_r == kms_pkg::ST_FAILED) && failLed && !routeEn)
		else $error("self-test failure not latched");

	// The failed state holds until the reset button
	fail_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE10
		(failLed && !resetRise && !tamperNow) |=> failLed)
		else $error("failure lamp dropped without reset");

	// Reset button restarts the whole sequence
	reset_rerun_a: assert property (@(posedge clk) disable iff (rst) // RULE9
		(resetRise && !tamperNow) |=> (state_r == kms_pkg::ST_INIT_PURGE) ##1 (&bufClear))
		else $error("reset button did not restart self-test");

	// Exactly one host lamp at all times
	sel_led_a: assert property (@(posedge clk) disable iff (rst) // RULE11
		$onehot(selLed) && (!routeEn || (routeSel == selLed)))
		else $error("selected-host indication lost");

	// Admin access only opens with the key present
	admin_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE12
		$rose(adminGrant) |-> $past(adminKeyS) && $past(adminReqS))
		else $error("admin access without key");

endmodule : kms_supervisor

// >>> verif/kms_test_model.sv
// Self-test engine and battery-backed tamper store facing the supervisor
`timescale 1ns/1ps
module kms_test_model (
	input  wire logic       clk,          // System clock
	input  wire logic       rst,          // Reset, active high
	input  wire logic       testStart,    // Step start pulse
	input  wire logic [1:0] testIdx,      // Step being run
	input  wire logic [2:0] failIdx,      // Step that fails, 4 for none
	input  wire logic       tamperStore,  // Tamper record write
	output logic            testDone,     // Step finished
	output logic            testPass,     // Step result
	output logic            tamperStored  // Record read back
);
	logic [1:0] dly_r;
	logic       busy_r;

	// Answer three cycles after start; idle result toggles so a stale pass never shows
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_r   <= 1'b0;
			dly_r    <= 2'h0;
			testDone <= 1'b0;
			testPass <= 1'b0;
		end else if (testStart) begin
			busy_r   <= 1'b1;
			dly_r    <= 2'h0;
			testDone <= 1'b0;
			testPass <= ~testPass;
		end else if (busy_r && dly_r == 2'h2) begin
			busy_r   <= 1'b0;
			testDone <= 1'b1;
			testPass <= ({1'b0, testIdx} != failIdx);
		end else begin
			dly_r    <= dly_r + 2'h1;
			testDone <= 1'b0;
			testPass <= ~testPass;
		end
	end

	// Battery-backed record: survives rst, only set, never cleared
	initial tamperStored = 1'b0;
	always @(posedge clk) begin
		if (tamperStore) begin
			tamperStored <= 1'b1;
		end
	end
endmodule : kms_test_model

// >>> verif/kms_supervisor_tb.sv
// Self-checking bench of the switch security supervisor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module kms_supervisor_tb;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] selBtn = 4'h0;
	logic       resetBtn = 1'b0;
	logic       enclosureOpen = 1'b0;
	logic       adminReq = 1'b0;
	logic       adminKey = 1'b0;
	logic       batteryFault = 1'b0;
	logic [2:0] failIdx = 3'h4;
	logic       testDone, testPass, tamperStored, routeEn, failLed, tamperLed;
	logic       tamperStore, testStart, adminGrant, adminDenied;
	logic [3:0] routeSel, bufClear, selLed;
	logic [1:0] testIdx;
	int         err_count = 0;
	int         tests_run = 0;

	always #20 clk = ~clk;

	kms_supervisor i_kms_supervisor (.clk(clk), .rst(rst), .selBtn(selBtn), .resetBtn(resetBtn),
		.enclosureOpen(enclosureOpen), .batteryFault(batteryFault), .tamperStored(tamperStored),
		.adminReq(adminReq), .adminKey(adminKey), .testDone(testDone), .testPass(testPass),
		.routeEn(routeEn), .routeSel(routeSel), .bufClear(bufClear), .selLed(selLed),
		.failLed(failLed), .tamperLed(tamperLed), .tamperStore(tamperStore),
		.testStart(testStart), .testIdx(testIdx), .adminGrant(adminGrant),
		.adminDenied(adminDenied));

	kms_test_model i_kms_test_model (.clk(clk), .rst(rst), .testStart(testStart),
		.testIdx(testIdx), .failIdx(failIdx), .tamperStore(tamperStore),
		.testDone(testDone), .testPass(testPass), .tamperStored(tamperStored));

	task end_sim;
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// Inputs always change 1 ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Bounded wait: 0 routeEn, 1 failLed, 2 tamperLed, 3 adminDenied, 4 adminGrant
	task waitFor(input int w, input logic v, input int lim);
		logic s;
		for (int i = 0; i < lim; i++) begin
			case (w)
				0: s = routeEn;
				1: s = failLed;
				2: s = tamperLed;
				3: s = adminDenied;
				default: s = adminGrant;
			endcase
			if (s === v)
				return;
			tick(1);
		end
		err_count++;
		$display("[ERR] wait %0d exp %h got %h", w, v, s);
		end_sim();
	endtask : waitFor

	task s_startup;
		tick(1);
		`CHK("bufClear", 4'hF, bufClear)
		`CHK("selLed", 4'h1, selLed)
		`CHK("routeEn", 1'b0, routeEn)
		`CHK("testStart", 1'b0, testStart)
		// First step starts on the edge after the purge count runs out
		tick(int'(kms_pkg::PURGE_LAST) + 1);
		`CHK("testStart", 1'b1, testStart)
		`CHK("testIdx", 2'h0, testIdx)
		`CHK("bufClear", 4'h0, bufClear)
		waitFor(0, 1'b1, 300);
		`CHK("routeSel", 4'h1, routeSel)
		`CHK("bufClear", 4'h0, bufClear)
		`CHK("testIdx", 2'h3, testIdx)
		`CHK("failLed", 1'b0, failLed)
	endtask : s_startup

	task s_switch;
		selBtn = 4'h4;
		waitFor(0, 1'b0, 10);
		`CHK("selLed", 4'h4, selLed)
		`CHK("bufClear", 4'h1, bufClear)
		selBtn = 4'h0;
		waitFor(0, 1'b1, 40);
		`CHK("routeSel", 4'h4, routeSel)
		`CHK("bufClear", 4'h0, bufClear)
		selBtn = 4'h4;
		tick(6);
		`CHK("routeEn", 1'b1, routeEn)
		selBtn = 4'h0;
	endtask : s_switch

	task s_admin;
		adminReq = 1'b1;
		waitFor(3, 1'b1, 10);
		`CHK("adminGrant", 1'b0, adminGrant)
		adminReq = 1'b0;
		adminKey = 1'b1;
		tick(3);
		adminReq = 1'b1;
		waitFor(4, 1'b1, 10);
		`CHK("routeEn", 1'b0, routeEn)
		adminReq = 1'b0;
		waitFor(4, 1'b0, 10);
		waitFor(0, 1'b1, 10);
	endtask : s_admin

	// Failing isolation step; failure must hold until the reset button
	task s_fail;
		failIdx = 3'h1;
		resetBtn = 1'b1;
		tick(4);
		`CHK("bufClear", 4'hF, bufClear)
		resetBtn = 1'b0;
		waitFor(1, 1'b1, 300);
		`CHK("routeEn", 1'b0, routeEn)
		`CHK("testIdx", 2'h1, testIdx)
		`CHK("selLed", 4'h4, selLed)
		tick(20);
		`CHK("failLed", 1'b1, failLed)
		`CHK("routeEn", 1'b0, routeEn)
		failIdx = 3'h4;
		resetBtn = 1'b1;
		tick(1);
		resetBtn = 1'b0;
		waitFor(1, 1'b0, 10);
		waitFor(0, 1'b1, 300);
	endtask : s_fail

	// Enclosure opened, then reset button and full rst must not revive routing
	task s_tamper;
		enclosureOpen = 1'b1;
		waitFor(2, 1'b1, 10);
		`CHK("routeEn", 1'b0, routeEn)
		`CHK("tamperStore", 1'b1, tamperStore)
		enclosureOpen = 1'b0;
		resetBtn = 1'b1;
		tick(1);
		resetBtn = 1'b0;
		tick(60);
		`CHK("routeEn", 1'b0, routeEn)
		`CHK("tamperLed", 1'b1, tamperLed)
		// Battery damaged while the supply is away; lockout must persist
		batteryFault = 1'b1;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		waitFor(2, 1'b1, 10);
		`CHK("tamperStore", 1'b1, tamperStore)
		batteryFault = 1'b0;
		tick(80);
		`CHK("routeEn", 1'b0, routeEn)
		`CHK("tamperLed", 1'b1, tamperLed)
	endtask : s_tamper

	initial begin
		tick(20);
		rst = 1'b0;
		s_startup();
		s_switch();
		s_admin();
		s_fail();
		s_tamper();
		end_sim();
	end
endmodule : kms_supervisor_tb
